// file: shared/capture_regs_pkg.sv
// Contract
// - Bit 0 shows word alignment found
// - Bits 1-3 show fast, slow, receiver lock
// - Bit 4 shows collection finished
// - Bit 5 shows capture finished
// - Bits 6-7 show frame A/B phase lock
// - Reset bit at 0x1D holds core reset
// - Display logic runs on own 50 MHz rate
// - Display has 32 positions in two rows
package capture_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] ADDR_CAPTURE_STATUS = 8'h04;
    localparam logic [7:0] ADDR_GLOBAL_RESET = 8'h1D;
    localparam logic [7:0] CAPTURE_STATUS_RESET = 8'h00;
    localparam logic [7:0] GLOBAL_RESET_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Status field positions
    localparam int STAT_WORD_ALIGN_OK = 0;
    localparam int STAT_FAST_PLL_LOCKED = 1;
    localparam int STAT_SLOW_PLL_LOCKED = 2;
    localparam int STAT_RECEIVER_PLL_LOCKED = 3;
    localparam int STAT_COLLECTION_DONE = 4;
    localparam int STAT_CAPTURE_DONE = 5;
    localparam int STAT_FRAME_A_LOCKED = 6;
    localparam int STAT_FRAME_B_LOCKED = 7;
    localparam int STATUS_WIDTH = 8;

    // Reset control field
    localparam int RESET_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SYS_CLK_MHZ = 250;
    localparam int DISP_CLK_MHZ = 50;
    localparam logic [2:0] DISP_DIV_LAST = 3'(SYS_CLK_MHZ / DISP_CLK_MHZ - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Display layout
    localparam int DISP_POSITIONS = 32;
    localparam logic [4:0] DISP_POS_LAST = 5'h1F;
    localparam logic [4:0] POS_STATE_0 = 5'h00;
    localparam logic [4:0] POS_STATE_1 = 5'h01;
    localparam logic [4:0] POS_STATE_2 = 5'h02;
    localparam logic [4:0] POS_CHANNEL = 5'h04;
    localparam logic [4:0] POS_COUNT_0 = 5'h10;
    localparam logic [4:0] POS_COUNT_1 = 5'h11;
    localparam logic [4:0] POS_COUNT_2 = 5'h12;
    localparam logic [4:0] POS_COUNT_3 = 5'h13;
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_A_MINUS_10 = 8'h37;
    localparam logic [7:0] CHAR_R = 8'h52;
    localparam logic [7:0] CHAR_D = 8'h44;
    localparam logic [7:0] CHAR_Y = 8'h59;
    localparam logic [7:0] CHAR_S = 8'h53;
    localparam logic [7:0] CHAR_T = 8'h54;

endpackage

// file: core/capture_status_reset_regs.sv
`timescale 1ns/100ps
module capture_status_reset_regs (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register access port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Status sources
    input wire logic i_word_align_ok,
    input wire logic i_fast_pll_locked,
    input wire logic i_slow_pll_locked,
    input wire logic i_receiver_pll_locked,
    input wire logic i_collection_done,
    input wire logic i_capture_done,
    input wire logic i_frame_a_phase_locked,
    input wire logic i_frame_b_phase_locked,
    // Core reset out
    output logic o_core_reset_n,
    // Display inputs
    input wire logic [2:0] i_selected_channel,
    input wire logic [15:0] i_sample_count,
    // Display character stream
    output logic [7:0] o_lcd_char,
    output logic [4:0] o_lcd_pos,
    output logic o_lcd_char_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Status synchronisers
    wire logic [7:0] status_src;
    logic [7:0] status_meta;
    logic [7:0] status_sync;

    assign status_src = {i_frame_b_phase_locked, i_frame_a_phase_locked, i_capture_done,
                         i_collection_done, i_receiver_pll_locked, i_slow_pll_locked,
                         i_fast_pll_locked, i_word_align_ok};

    genvar gi;
    generate
        for (gi = 0; gi < capture_regs_pkg::STATUS_WIDTH; gi++) begin : g_sync
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    status_meta[gi] <= 1'b0;
                    status_sync[gi] <= 1'b0;
                end else begin
                    status_meta[gi] <= status_src[gi];
                    status_sync[gi] <= status_meta[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire logic hit_status;
    wire logic hit_reset;
    wire logic [7:0] next_rdata;
    logic reset_hold;

    assign hit_status = i_reg_addr == capture_regs_pkg::ADDR_CAPTURE_STATUS;
    assign hit_reset = i_reg_addr == capture_regs_pkg::ADDR_GLOBAL_RESET;
    // live status view; reset register is write-only
    assign next_rdata = hit_status ? status_sync : capture_regs_pkg::READ_UNMAPPED;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= capture_regs_pkg::CAPTURE_STATUS_RESET;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // not self-clearing, host must write 0
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reset_hold <= capture_regs_pkg::GLOBAL_RESET_RESET[capture_regs_pkg::RESET_BIT];
        end else if (i_reg_wr && hit_reset) begin
            reset_hold <= i_reg_wdata[capture_regs_pkg::RESET_BIT];
        end
    end

    // Registered so the core reset never glitches on decode
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_reset_n <= 1'b0;
        end else begin
            o_core_reset_n <= ~reset_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display driver, reset only by the board reset
    logic [2:0] disp_div;
    wire logic disp_tick;
    logic [4:0] disp_pos;
    logic [7:0] disp_char;

    assign disp_tick = disp_div == capture_regs_pkg::DISP_DIV_LAST;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            disp_div <= 3'h0;
        end else if (disp_tick) begin
            disp_div <= 3'h0;
        end else begin
            disp_div <= disp_div + 3'h1;
        end
    end

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        if (nib < 4'hA) begin
            hex_char = capture_regs_pkg::CHAR_ZERO + {4'h0, nib};
        end else begin
            hex_char = capture_regs_pkg::CHAR_A_MINUS_10 + {4'h0, nib};
        end
    endfunction

    always_comb begin
        case (disp_pos)
            capture_regs_pkg::POS_STATE_0: disp_char = capture_regs_pkg::CHAR_R;
            capture_regs_pkg::POS_STATE_1: begin
                disp_char = reset_hold ? capture_regs_pkg::CHAR_S : capture_regs_pkg::CHAR_D;
            end
            capture_regs_pkg::POS_STATE_2: begin
                disp_char = reset_hold ? capture_regs_pkg::CHAR_T : capture_regs_pkg::CHAR_Y;
            end
            capture_regs_pkg::POS_CHANNEL: disp_char = hex_char({1'b0, i_selected_channel});
            capture_regs_pkg::POS_COUNT_0: disp_char = hex_char(i_sample_count[15:12]);
            capture_regs_pkg::POS_COUNT_1: disp_char = hex_char(i_sample_count[11:8]);
            capture_regs_pkg::POS_COUNT_2: disp_char = hex_char(i_sample_count[7:4]);
            capture_regs_pkg::POS_COUNT_3: disp_char = hex_char(i_sample_count[3:0]);
            default: disp_char = capture_regs_pkg::CHAR_SPACE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            disp_pos <= 5'h00;
            o_lcd_char <= capture_regs_pkg::CHAR_SPACE;
            o_lcd_pos <= 5'h00;
            o_lcd_char_valid <= 1'b0;
        end else begin
            o_lcd_char_valid <= disp_tick;
            if (disp_tick) begin
                o_lcd_char <= disp_char;
                o_lcd_pos <= disp_pos;
                disp_pos <= disp_pos + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_status_align: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_rd && hit_status && $past(i_rst_n, 3)) |=>
            o_reg_rdata[0] == $past(i_word_align_ok, 3))
        else $error("status bit 0 does not follow word alignment");

    a_status_plls: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_rd && hit_status && $past(i_rst_n, 3)) |=>
            o_reg_rdata[3:1] == $past({i_receiver_pll_locked, i_slow_pll_locked,
                                       i_fast_pll_locked}, 3))
        else $error("status bits 3:1 do not follow pll locks");

    a_status_collect: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_rd && hit_status && $past(i_rst_n, 3)) |=>
            o_reg_rdata[4] == $past(i_collection_done, 3))
        else $error("status bit 4 does not follow collection done");

    a_status_capture: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_rd && hit_status && $past(i_rst_n, 3)) |=>
            o_reg_rdata[5] == $past(i_capture_done, 3))
        else $error("status bit 5 does not follow capture done");

    a_status_frames: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_rd && hit_status && $past(i_rst_n, 3)) |=>
            o_reg_rdata[7:6] == $past({i_frame_b_phase_locked, i_frame_a_phase_locked}, 3))
        else $error("status bits 7:6 do not follow frame locks");

    a_reset_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_wr && hit_reset && i_reg_wdata[0]) ##1 !(i_reg_wr && hit_reset)
            |=> !o_core_reset_n)
        else $error("core reset not held after reset bit set");

    a_disp_rate: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_lcd_char_valid |=> !o_lcd_char_valid [*4] ##1 o_lcd_char_valid)
        else $error("display strobe not at 50 MHz rate");

    a_disp_wrap: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_lcd_char_valid && o_lcd_pos == 5'h1F) |-> ##5 (o_lcd_char_valid && o_lcd_pos == 5'h00))
        else $error("display does not wrap after 32 positions");

    a_disp_ready: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_lcd_char_valid && o_lcd_pos == 5'h01) |-> o_lcd_char == ($past(reset_hold) ? 8'h53 : 8'h44))
        else $error("ready or reset indication wrong");

    a_read_reset: assert property (
        @(posedge i_clk_sys)
        $rose(i_rst_n) |-> (o_reg_rdata == 8'h00 && !o_reg_rvalid))
        else $error("read data not zero after reset");

endmodule // capture_status_reset_regs

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_rd = 1'b0;
    logic [7:0] stat = 8'h00;
    logic [2:0] i_selected_channel = 3'h5;
    logic [15:0] i_sample_count = 16'h3AC5;
    logic [7:0] o_reg_rdata;
    logic [7:0] o_lcd_char;
    logic [4:0] o_lcd_pos;
    logic o_reg_rvalid;
    logic o_core_reset_n;
    logic o_lcd_char_valid;
    logic [7:0] d;
    int gap;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // Upper byte drives the status sources, lower byte is the expected read
    logic [15:0] rows [10] = '{16'h0101, 16'h0202, 16'h0404, 16'h0808, 16'h1010,
        16'h2020, 16'h4040, 16'h8080, 16'hA5A5, 16'hFFFF};
    // Display position and character expected there
    logic [12:0] lcd_rows [9] = '{{5'h00, 8'h52}, {5'h01, 8'h44}, {5'h02, 8'h59},
        {5'h04, 8'h35}, {5'h10, 8'h33}, {5'h11, 8'h41}, {5'h12, 8'h43},
        {5'h13, 8'h35}, {5'h1F, 8'h20}};

    capture_status_reset_regs dut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_word_align_ok(stat[0]), .i_fast_pll_locked(stat[1]),
        .i_slow_pll_locked(stat[2]), .i_receiver_pll_locked(stat[3]),
        .i_collection_done(stat[4]), .i_capture_done(stat[5]),
        .i_frame_a_phase_locked(stat[6]), .i_frame_b_phase_locked(stat[7]),
        .o_core_reset_n(o_core_reset_n), .i_selected_channel(i_selected_channel),
        .i_sample_count(i_sample_count), .o_lcd_char(o_lcd_char),
        .o_lcd_pos(o_lcd_pos), .o_lcd_char_valid(o_lcd_char_valid)
    );

    always #2 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard: whole run needs roughly 500 cycles
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Valid strobe stands for one cycle only, so look right after the taking edge
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_clk_sys);
        i_reg_rd = 1'b1;
        i_reg_addr = addr;
        @(posedge i_clk_sys);
        #1;
        check("rvalid", {7'h00, o_reg_rvalid}, 8'h01);
        data = o_reg_rdata;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_clk_sys);
        i_reg_wr = 1'b1;
        i_reg_addr = addr;
        i_reg_wdata = data;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask

    // Bounded wait for a display character at one position
    task automatic lcd_at(input logic [4:0] p, output logic [7:0] ch, output int n);
        n = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end while (!(o_lcd_char_valid === 1'b1 && o_lcd_pos === p) && n < 200);
        ch = o_lcd_char;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1;
        check("core reset in reset", {7'h00, o_core_reset_n}, 8'h00);
        check("rdata in reset", o_reg_rdata, 8'h00);
        @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        check("core reset released", {7'h00, o_core_reset_n}, 8'h01);
        reg_read(8'h04, d);
        check("status after reset", d, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk_sys);
            stat = rows[i][15:8];
            repeat (3) @(posedge i_clk_sys);
            reg_read(8'h04, d);
            check("status bits", d, rows[i][7:0]);
        end
        $display("status table done");
        reg_read(8'h1D, d);
        check("write-only read", d, 8'h00);
        reg_read(8'h55, d);
        check("unmapped read", d, 8'h00);
        reg_write(8'h04, 8'h00);
        stat = 8'h3C;
        repeat (3) @(posedge i_clk_sys);
        reg_read(8'h04, d);
        check("status after write", d, 8'h3C);
        $display("access test done");
        reg_write(8'h1D, 8'h01);
        repeat (3) @(posedge i_clk_sys);
        #1;
        check("core reset held", {7'h00, o_core_reset_n}, 8'h00);
        lcd_at(5'h01, d, gap);
        check("display reset text", d, 8'h53);
        reg_read(8'h04, d);
        check("status during core reset", d, 8'h3C);
        repeat (40) @(posedge i_clk_sys);
        #1;
        check("reset bit stays", {7'h00, o_core_reset_n}, 8'h00);
        // Upper bits set too: only bit 0 may matter
        reg_write(8'h1D, 8'hFE);
        repeat (3) @(posedge i_clk_sys);
        #1;
        check("core reset freed", {7'h00, o_core_reset_n}, 8'h01);
        $display("core reset test done");
        for (int i = 0; i < 9; i++) begin
            lcd_at(lcd_rows[i][12:8], d, gap);
            check("display char", d, lcd_rows[i][7:0]);
        end
        lcd_at(5'h00, d, gap);
        lcd_at(5'h01, d, gap);
        check("display spacing", 8'(gap), 8'h05);
        $display("display test done");
        stop_test();
    end
endmodule // testbench
